// >>> pkg/rlm_regs.vh
// register map, field positions and reset values of the limit monitor
// assumes a 32-bit avalon-mm slave with byte addresses, one word a register
`ifndef RLM_REGS_VH
`define RLM_REGS_VH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define RLM_IDX_CONFIG2 4'h2
`define RLM_IDX_STATUS 4'h3
`define RLM_IDX_LOWER 4'h4
`define RLM_IDX_UPPER 4'h5
`define RLM_IDX_IRQ_MASK 4'h6
`define RLM_IDX_IRQ_STAT 4'h7

// ****************************************************************
// word fields
// ****************************************************************
`define RLM_ADDR_HI 15
`define RLM_ADDR_LO 12
`define RLM_LIMIT_HI 11
`define RLM_LIMIT_LO 0
`define RLM_CFG_ONEWIRE_BIT 8
`define RLM_CFG_RST_HI 7
`define RLM_CFG_RST_LO 0

// ****************************************************************
// limit flag positions in the status word
// ****************************************************************
`define RLM_BIT_A_UNDER 0
`define RLM_BIT_A_OVER 1
`define RLM_BIT_B_UNDER 4
`define RLM_BIT_B_OVER 5
`define RLM_FLAG_MASK 16'h0033

// ****************************************************************
// reset values and command codes
// ****************************************************************
`define RLM_LOWER_RST 12'h000
`define RLM_UPPER_RST 12'hfff
`define RLM_SOFT_RST_CODE 8'h3c
`define RLM_HARD_RST_CODE 8'hff
`define RLM_LOWER_PAD 4'h0
`define RLM_UPPER_PAD 4'hf

`endif

// >>> rtl/rlm_cmp.v
// one channel's compare against the lower and upper limit
// assumes a result already aligned to 16 bits, same clock as the caller
`timescale 1ns/1ns
`include "rlm_regs.vh"

module rlm_cmp (
   // aligned result
   input wire [15:0] i_result,
   // limit fields
   input wire [11:0] i_lower_field,
   input wire [11:0] i_upper_field,
   // compare outcome
   output wire o_under,
   output wire o_over
);

   // ****************************************************************
   // compare values built from the limit fields
   // ****************************************************************
   wire [15:0] lower_val;
   wire [15:0] upper_val;

   // low nibble zero under the lower field
   assign lower_val = {i_lower_field, `RLM_LOWER_PAD};
   // low nibble all ones under the upper field
   assign upper_val = {i_upper_field, `RLM_UPPER_PAD};

   // strict compares: equal to a limit is no violation
   assign o_under = (i_result < lower_val);
   assign o_over = (i_result > upper_val);

endmodule

// >>> rtl/rlm_top.v
// result limit monitor for a dual-channel converter, avalon-mm slave
// assumes results and their valid strobe come from logic on i_clk_sys
`timescale 1ns/1ns
`include "rlm_regs.vh"

module rlm_top #(
   parameter RES_W = 16
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_sys_rst,
   // avalon-mm slave
   input wire [5:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // conversion results
   input wire i_conv_valid,
   input wire [RES_W-1:0] i_result_a,
   input wire [RES_W-1:0] i_result_b,
   // status outputs
   output wire o_irq,
   output wire o_one_wire
);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // left-justify a result of RES_W bits into 16 bits
   function [15:0] align16;
      input [RES_W-1:0] res;
      reg [31:0] wide;
      begin
         // zeros below the result put its top bit at bit 31
         wide = {res, {(32-RES_W){1'b0}}};
         align16 = wide[31:16];
      end
   endfunction

   // merge the two low byte lanes of a write into an old value
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] wdata;
      input [3:0] be;
      begin
         merge16 = old;
         if (be[0]) begin
            merge16[7:0] = wdata[7:0];
         end
         if (be[1]) begin
            merge16[15:8] = wdata[15:8];
         end
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   reg ack_reg;
   reg [11:0] lower_reg;
   reg [11:0] upper_reg;
   reg [11:0] lower_next;
   reg [11:0] upper_next;
   reg [15:0] flag_reg;
   reg [15:0] flag_next;
   reg [15:0] snap_reg;
   reg [15:0] irq_stat_reg;
   reg [15:0] irq_stat_next;
   reg [15:0] irq_mask_reg;
   reg [15:0] irq_mask_next;
   reg one_wire_reg;
   reg one_wire_next;
   reg [15:0] rd_word;

   wire req;
   wire take;
   wire [3:0] idx;
   wire idx_ok;
   wire wr_take;
   wire rd_take;
   wire [15:0] wr_lo;
   wire a_under;
   wire a_over;
   wire b_under;
   wire b_over;
   wire [15:0] set_vec;
   wire soft_rst;
   wire hard_rst;
   wire [15:0] lower_wr;
   wire [15:0] upper_wr;

   // ****************************************************************
   // bus handshake
   // ****************************************************************

   // one wait state: request seen, then taken at the next edge
   assign req = i_avs_read | i_avs_write;
   assign take = req & ack_reg;
   assign o_avs_waitrequest = req & ~ack_reg;
   assign idx = i_avs_address[5:2];
   assign idx_ok = (i_avs_address[1:0] == 2'h0);
   assign wr_take = take & i_avs_write & idx_ok;
   assign rd_take = take & i_avs_read & idx_ok;
   assign wr_lo = merge16(16'h0, i_avs_writedata, i_avs_byteenable);
   // limit words after a write, cut to the 12-bit field where used
   assign lower_wr = merge16({4'h0, lower_reg}, i_avs_writedata,
      i_avs_byteenable);
   assign upper_wr = merge16({4'h0, upper_reg}, i_avs_writedata,
      i_avs_byteenable);

   // wait-state flop, cleared once the request is taken
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // ****************************************************************
   // comparators
   // ****************************************************************

   // both channels checked against both limits independently
   rlm_cmp u_cmp_a (
      .i_result(align16(i_result_a)),
      .i_lower_field(lower_reg),
      .i_upper_field(upper_reg),
      .o_under(a_under),
      .o_over(a_over)
   );

   rlm_cmp u_cmp_b (
      .i_result(align16(i_result_b)),
      .i_lower_field(lower_reg),
      .i_upper_field(upper_reg),
      .o_under(b_under),
      .o_over(b_over)
   );

   // violations of this conversion placed at their status bits
   assign set_vec[`RLM_BIT_A_UNDER] = i_conv_valid & a_under;
   assign set_vec[`RLM_BIT_A_OVER] = i_conv_valid & a_over;
   assign set_vec[3:2] = 2'h0;
   assign set_vec[`RLM_BIT_B_UNDER] = i_conv_valid & b_under;
   assign set_vec[`RLM_BIT_B_OVER] = i_conv_valid & b_over;
   assign set_vec[15:6] = 10'h0;

   // ****************************************************************
   // reset commands in the second config register
   // ****************************************************************
   assign soft_rst = wr_take & (idx == `RLM_IDX_CONFIG2) & i_avs_byteenable[0]
      & (i_avs_writedata[7:0] == `RLM_SOFT_RST_CODE);
   assign hard_rst = wr_take & (idx == `RLM_IDX_CONFIG2) & i_avs_byteenable[0]
      & (i_avs_writedata[7:0] == `RLM_HARD_RST_CODE);

   // ****************************************************************
   // next-state logic
   // ****************************************************************

   // flags: a new violation always wins over a clear in the same cycle
   always @* begin
      flag_next = flag_reg;
      if (soft_rst | hard_rst) begin
         flag_next = 16'h0;
      end else if (rd_take & (idx == `RLM_IDX_STATUS)) begin
         // clear only what the read actually reported
         flag_next = flag_reg & ~snap_reg;
      end
      flag_next = (flag_next | set_vec) & `RLM_FLAG_MASK;
   end

   // interrupt status: sticky, write one to clear, set wins
   always @* begin
      irq_stat_next = irq_stat_reg;
      if (wr_take & (idx == `RLM_IDX_IRQ_STAT)) begin
         irq_stat_next = irq_stat_reg & ~wr_lo;
      end
      irq_stat_next = (irq_stat_next | set_vec) & `RLM_FLAG_MASK;
   end

   // writable registers; hard reset restores their defaults
   always @* begin
      lower_next = lower_reg;
      upper_next = upper_reg;
      irq_mask_next = irq_mask_reg;
      one_wire_next = one_wire_reg;
      if (hard_rst) begin
         lower_next = `RLM_LOWER_RST;
         upper_next = `RLM_UPPER_RST;
         irq_mask_next = 16'h0;
         one_wire_next = 1'b0;
      end else if (wr_take) begin
         case (idx)
            `RLM_IDX_LOWER: begin
               lower_next = lower_wr[11:0];
            end
            `RLM_IDX_UPPER: begin
               upper_next = upper_wr[11:0];
            end
            `RLM_IDX_IRQ_MASK: begin
               irq_mask_next = merge16(irq_mask_reg, i_avs_writedata,
                  i_avs_byteenable) & `RLM_FLAG_MASK;
            end
            `RLM_IDX_CONFIG2: begin
               if (i_avs_byteenable[1]) begin
                  one_wire_next = i_avs_writedata[`RLM_CFG_ONEWIRE_BIT];
               end
            end
            default: begin
               lower_next = lower_reg;
            end
         endcase
      end
   end

   // ****************************************************************
   // read word, with the register index in bits 15 to 12 for indexes 2 to 7
   // ****************************************************************
   always @* begin
      rd_word = 16'h0;
      case (i_avs_address[5:2])
         `RLM_IDX_CONFIG2: begin
            rd_word[`RLM_CFG_ONEWIRE_BIT] = one_wire_reg;
         end
         `RLM_IDX_STATUS: begin
            rd_word = flag_reg & `RLM_FLAG_MASK;
         end
         `RLM_IDX_LOWER: begin
            rd_word[11:0] = lower_reg;
         end
         `RLM_IDX_UPPER: begin
            rd_word[11:0] = upper_reg;
         end
         `RLM_IDX_IRQ_MASK: begin
            rd_word = irq_mask_reg;
         end
         `RLM_IDX_IRQ_STAT: begin
            rd_word = irq_stat_reg;
         end
         default: begin
            rd_word = 16'h0;
         end
      endcase
      if (rd_word != 16'h0 || i_avs_address[5:2] == `RLM_IDX_CONFIG2
         || (i_avs_address[5:2] >= `RLM_IDX_CONFIG2
         && i_avs_address[5:2] <= `RLM_IDX_IRQ_STAT)) begin
         rd_word[15:12] = i_avs_address[5:2];
      end
      if (!idx_ok) begin
         rd_word = 16'h0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************

   // limits, reset so that no result can violate by default
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lower_reg <= `RLM_LOWER_RST;
         upper_reg <= `RLM_UPPER_RST;
      end else begin
         lower_reg <= lower_next;
         upper_reg <= upper_next;
      end
   end

   // flags, interrupt state and config bit
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flag_reg <= 16'h0;
         irq_stat_reg <= 16'h0;
         irq_mask_reg <= 16'h0;
         one_wire_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         one_wire_reg <= one_wire_next;
      end
   end

   // read data latched in the wait state, held through the taking edge
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_avs_readdata <= 32'h0;
         snap_reg <= 16'h0;
      end else if (i_avs_read & ~ack_reg) begin
         o_avs_readdata <= {16'h0, rd_word};
         snap_reg <= rd_word & `RLM_FLAG_MASK;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_irq = |(irq_stat_reg & irq_mask_reg);
   assign o_one_wire = one_wire_reg;

endmodule

// >>> dv/rlm_chk.sv
// checker for the limit monitor: bus timing, readback and limit flags
// assumes one clock; shadows limits and flags from the port traffic
`timescale 1ns/1ns
`include "rlm_regs.vh"
module rlm_chk #(
   parameter RES_W = 16
) (
   // clock and reset
   input wire i_clk_sys,
   input wire i_sys_rst,
   // register bus
   input wire [5:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   // results and status
   input wire i_conv_valid,
   input wire [RES_W-1:0] i_result_a,
   input wire [RES_W-1:0] i_result_b,
   input wire o_irq,
   input wire o_one_wire
);
   // ****************************************
   // shadow of limits and flags
   // ****************************************
   reg [11:0] lo_reg;
   reg [11:0] hi_reg;
   reg [5:0] fl_reg;
   wire req = i_avs_read | i_avs_write;
   wire take = req & ~o_avs_waitrequest;
   wire [3:0] idx = i_avs_address[5:2];
   wire ok = take & (i_avs_address[1:0] == 2'b00);
   wire rd = ok & i_avs_read;
   wire wr = ok & i_avs_write;
   wire [15:0] wd = i_avs_writedata[15:0];
   wire [3:0] be = i_avs_byteenable;
   wire [15:0] ra = 16'(i_result_a) << (16 - RES_W);
   wire [15:0] rb = 16'(i_result_b) << (16 - RES_W);
   wire [15:0] lo16 = {lo_reg, `RLM_LOWER_PAD};
   wire [15:0] hi16 = {hi_reg, `RLM_UPPER_PAD};
   // violations of both channels in status bit order
   wire [5:0] vio = {rb > hi16, rb < lo16, 2'b00,
      ra > hi16, ra < lo16};
   wire cfg = wr & (idx == `RLM_IDX_CONFIG2) & be[0];
   wire hard = cfg & (wd[7:0] == `RLM_HARD_RST_CODE);
   wire flush = cfg & (wd[7:0] == `RLM_SOFT_RST_CODE) | hard;
   wire st_rd = rd & (idx == `RLM_IDX_STATUS);
   wire [5:0] clr = flush ? 6'h3f : (st_rd ? o_avs_readdata[5:0] : 6'h00);
   // shadow registers follow taken writes, conversions and status reads
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lo_reg <= `RLM_LOWER_RST;
         hi_reg <= `RLM_UPPER_RST;
         fl_reg <= 6'h00;
      end else begin
         fl_reg <= (fl_reg & ~clr) | (i_conv_valid ? vio : 6'h00);
         if (hard) begin
            lo_reg <= `RLM_LOWER_RST;
            hi_reg <= `RLM_UPPER_RST;
         end
         if (wr && be[0] && idx == `RLM_IDX_LOWER) lo_reg[7:0] <= wd[7:0];
         if (wr && be[1] && idx == `RLM_IDX_LOWER) lo_reg[11:8] <= wd[11:8];
         if (wr && be[0] && idx == `RLM_IDX_UPPER) hi_reg[7:0] <= wd[7:0];
         if (wr && be[1] && idx == `RLM_IDX_UPPER) hi_reg[11:8] <= wd[11:8];
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   chk_wait_once:
   assert property ((req && o_avs_waitrequest) ##1 req |-> !o_avs_waitrequest)
      else $error("bus answer missing after one wait cycle");
   chk_first_wait:
   assert property ($rose(req) |-> o_avs_waitrequest)
      else $error("new request answered without a wait cycle");
   chk_flag_report:
   assert property (st_rd |-> o_avs_readdata[5:0] == $past(fl_reg))
      else $error("limit flags differ from recorded violations");
   chk_rsvd_zero:
   assert property (st_rd |-> o_avs_readdata[11:6] == 6'h00
      && o_avs_readdata[3:2] == 2'b00) else $error("reserved status bit set");
   chk_index_echo:
   assert property (rd && idx >= 4'h2 && idx <= 4'h7
      |-> o_avs_readdata[15:12] == idx) else $error("index field wrong");
   chk_limit_back:
   assert property (rd && (idx == 4'h4 || idx == 4'h5) |->
      o_avs_readdata[11:0] == (idx == 4'h4 ? lo_reg : hi_reg))
      else $error("limit readback wrong");
   chk_unmapped_zero:
   assert property (rd && (idx < 4'h2 || idx > 4'h7) |-> o_avs_readdata == 0)
      else $error("unmapped read not zero");
   chk_upper_half:
   assert property (take |-> o_avs_readdata[31:16] == 16'h0000)
      else $error("upper half of read data not zero");
   cov_flag_read: cover property (st_rd && o_avs_readdata[5:0] != 6'h00);
   cov_flush: cover property (flush);
   cov_vio: cover property (i_conv_valid && vio != 6'h00);
endmodule

bind rlm_top rlm_chk #(.RES_W(RES_W)) u_chk (
   .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_conv_valid(i_conv_valid),
   .i_result_a(i_result_a), .i_result_b(i_result_b),
   .o_irq(o_irq), .o_one_wire(o_one_wire)
);

// >>> dv/tb_top.sv
// self-checking bench for the limit monitor
// assumes the design answers each bus request after its wait cycle
`timescale 1ns/1ns
module tb_top;
   reg i_clk_sys = 1'b0;
   reg i_sys_rst = 1'b1;
   reg [5:0] i_avs_address = 6'h00;
   reg i_avs_read = 1'b0;
   reg i_avs_write = 1'b0;
   reg [31:0] i_avs_writedata = 32'h00000000;
   reg i_conv_valid = 1'b0;
   reg [15:0] i_result_a = 16'h0000;
   reg [15:0] i_result_b = 16'h0000;
   wire [31:0] o_avs_readdata;
   wire o_avs_waitrequest;
   wire o_irq;
   wire o_one_wire;
   integer mismatches = 0;
   integer n_compared = 0;
   // ****************************************
   // design and clock
   // ****************************************
   rlm_top #(.RES_W(16)) i_dut (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_conv_valid(i_conv_valid),
      .i_result_a(i_result_a), .i_result_b(i_result_b),
      .o_irq(o_irq), .o_one_wire(o_one_wire)
   );
   initial forever #5 i_clk_sys = ~i_clk_sys;
   // ****************************************
   // shared tasks
   // ****************************************
   task report_and_stop;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // one transfer, held until waitrequest is low at the taking edge
   task bus(input rd, input [3:0] idx, input [15:0] wd, output [31:0] q);
      integer n;
      begin
         @(posedge i_clk_sys);
         i_avs_read <= rd;
         i_avs_write <= ~rd;
         i_avs_address <= {idx, 2'b00};
         i_avs_writedata <= {16'h0000, wd};
         // waitrequest and read data are judged at the rising edge itself
         n = 0;
         @(posedge i_clk_sys);
         while (o_avs_waitrequest !== 1'b0 && n < 20) begin
            n = n + 1;
            @(posedge i_clk_sys);
         end
         if (n >= 20) begin
            mismatches = mismatches + 1;
            report_and_stop;
         end else begin
            q = o_avs_readdata;
            i_avs_read <= 1'b0;
            i_avs_write <= 1'b0;
         end
      end
   endtask
   task wr(input [3:0] idx, input [15:0] wd);
      reg [31:0] q;
      begin
         bus(1'b0, idx, wd, q);
      end
   endtask
   task rd(input [3:0] idx, input [31:0] exp);
      reg [31:0] q;
      begin
         bus(1'b1, idx, 16'h0000, q);
         chk("readdata", q, exp);
      end
   endtask
   task conv(input [15:0] a, input [15:0] b);
      begin
         @(posedge i_clk_sys);
         i_conv_valid <= 1'b1;
         i_result_a <= a;
         i_result_b <= b;
         @(posedge i_clk_sys);
         i_conv_valid <= 1'b0;
      end
   endtask
   task irq_is(input exp);
      begin
         @(posedge i_clk_sys);
         @(negedge i_clk_sys);
         chk("irq", {31'h0, o_irq}, {31'h0, exp});
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_defaults;
      begin
         rd(4'h4, 32'h00004000);
         rd(4'h5, 32'h00005fff);
         rd(4'h3, 32'h00003000);
         rd(4'hf, 32'h00000000);
      end
   endtask
   // equal values are no violation, one step past them is
   task t_limits;
      begin
         wr(4'h4, 16'h4100);
         wr(4'h5, 16'h5800);
         rd(4'h4, 32'h00004100);
         rd(4'h5, 32'h00005800);
         conv(16'h1000, 16'h800f);
         rd(4'h3, 32'h00003000);
         conv(16'h0fff, 16'h8010);
         conv(16'h4000, 16'h4000);
         rd(4'h3, 32'h00003021);
         rd(4'h3, 32'h00003000);
         conv(16'h8010, 16'h0fff);
         rd(4'h3, 32'h00003012);
      end
   endtask
   task t_rsvd_soft;
      begin
         wr(4'h3, 16'h3fff);
         rd(4'h3, 32'h00003000);
         conv(16'h0000, 16'hffff);
         wr(4'h2, 16'h203c);
         rd(4'h3, 32'h00003000);
         rd(4'h4, 32'h00004100);
      end
   endtask
   // only channel a under-limit is let through to the interrupt
   task t_irq;
      begin
         wr(4'h7, 16'h7033);
         wr(4'h6, 16'h6001);
         irq_is(1'b0);
         conv(16'h4000, 16'h0000);
         irq_is(1'b0);
         conv(16'h0000, 16'h4000);
         irq_is(1'b1);
         rd(4'h7, 32'h00007011);
         wr(4'h7, 16'h7001);
         irq_is(1'b0);
      end
   endtask
   // one-wire bit, then the hard reset code restores the limits, mask, one-wire bit and flags
   task t_hard;
      begin
         wr(4'h2, 16'h2100);
         @(negedge i_clk_sys);
         chk("one_wire", {31'h0, o_one_wire}, 32'h00000001);
         rd(4'h2, 32'h00002100);
         conv(16'h0000, 16'h0000);
         wr(4'h4, 16'h4123);
         wr(4'h2, 16'h20ff);
         rd(4'h3, 32'h00003000);
         rd(4'h4, 32'h00004000);
         rd(4'h5, 32'h00005fff);
         rd(4'h6, 32'h00006000);
         @(negedge i_clk_sys);
         chk("one_wire", {31'h0, o_one_wire}, 32'h00000000);
         chk("irq", {31'h0, o_irq}, 32'h00000000);
      end
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      t_defaults;
      t_limits;
      t_rsvd_soft;
      t_irq;
      t_hard;
      report_and_stop;
   end
endmodule
